// >>> rtl/cpm_pkg.sv
// package for the coprocessor move port: commands, types and sizes
package cpm_pkg;
  localparam int          WORD_W     = 32;
  localparam int          REG_AW     = 5;   // register sequence list index width
  localparam int          COUNT_W    = 5;   // transfer count field width
  localparam int          FIFO_DEPTH = 8;
  localparam logic [5:0]  FULL_COUNT = 6'h20; // count field 0 means 32 transfers
  localparam logic        HALF_ORDER_RESET = 1'b0;

  typedef enum logic [1:0] {
    CPM_OP_TO_HOST1 = 2'b00,  // one register to one host register
    CPM_OP_TO_HOST2 = 2'b01,  // double value to two host registers
    CPM_OP_BLOCK    = 2'b10   // memory words into the register file
  } cpm_op_t;

  typedef enum logic [1:0] {
    CPM_FMT_INT    = 2'b00,
    CPM_FMT_SINGLE = 2'b01,
    CPM_FMT_DOUBLE = 2'b10
  } cpm_fmt_t;

  typedef struct packed {
    cpm_op_t              op;
    cpm_fmt_t             fmt;
    logic [REG_AW-1:0]    reg_idx;   // source or first destination register
    logic [COUNT_W-1:0]   count;     // constant or host-register count, 0 = maximum
  } cpm_cmd_t;

  typedef struct packed {
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } cpm_pair_t;

  typedef enum logic [1:0] {
    CPM_IDLE  = 2'b00,
    CPM_READ  = 2'b01,
    CPM_SEND2 = 2'b10,
    CPM_LOAD  = 2'b11
  } cpm_state_t;
endpackage

// >>> rtl/cpm_move_port.sv
// register file move engine of the coprocessor, with the word fifo
// Notes on behaviour
// (RL1) a double move to two host registers sends both halves, order set by the half-order bit.
// (RL2) with the half-order bit at 1 every double transfer carries the low half first.
// (RL3) with the half-order bit at 0 the high half goes first, and the bit resets to 0.
// (RL4) a register-count block load makes 32 transfers for 0 and n transfers for 1 to 31; here a double count of 1 to 16 makes 2n transfers.
// (RL5) the host gives an even count for double register-count loads, odd counts are undefined.
// (RL6) the host adds 32 to its bit pointer after each post-increment transfer.
// (RL7) the destination steps after every word for single or integer, every second for double.
// (RL8) pre-decrement loads still step the destination through the register sequence.
// (RL9) a constant double load of n values makes 2n word transfers.
// (RL10) constant counts run 1..32 single or 1..16 double, with the maximum coded as zero.
`timescale 1ns/10ps

module cpm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      fill_q;
  logic             push;
  logic             pop;

  // honest flags straight from the fill count
  assign inReady  = (fill_q != DEPTH[AW:0]);
  assign outValid = (fill_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      fill_q  <= '0;
    end else begin
      if (push) begin
        mem[wrPtr_q] <= inData;
        wrPtr_q      <= wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= rdPtr_q + 1'b1;
      end
      fill_q <= fill_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module cpm_move_port (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire logic                     cmdValid,
  output logic                          cmdReady,
  input  wire cpm_pkg::cpm_cmd_t        cmd,
  input  wire logic                     halfOrderWe,
  input  wire logic                     halfOrderIn,
  output logic                          halfOrder,
  input  wire logic                     memValid,
  output logic                          memReady,
  input  wire logic [cpm_pkg::WORD_W-1:0] memData,
  output logic                          hostValid,
  input  wire logic                     hostReady,
  output logic [cpm_pkg::WORD_W-1:0]    hostData,
  output logic                          busy
);
  localparam int W  = cpm_pkg::WORD_W;
  localparam int AW = cpm_pkg::REG_AW;

  typedef struct packed {
    cpm_pkg::cpm_state_t st;
    cpm_pkg::cpm_op_t    op;
    logic                isDbl;
    logic [AW-1:0]       regIdx;
    logic [5:0]          left;      // word transfers still to go
    logic                second;    // next word is second half of a double
    logic [W-1:0]        holdHalf;  // first half waiting for its partner
    logic [W-1:0]        pendSecond;
    logic                halfOrder;
    logic                hostValid;
    logic [W-1:0]        hostData;
    logic                cmdReady;
    logic                busy;
  } cpm_state_s_t;

  cpm_state_s_t s_q;
  cpm_state_s_t s_d;

  // 64-bit register file, addressed along the register sequence list
  logic [2*W-1:0] regFile [2**AW];
  logic           fifoValid;
  logic           fifoPop;
  logic [W-1:0]   fifoData;
  logic           regWe;
  logic [2*W-1:0] regWData;
  logic [2*W-1:0] rdVal;
  logic [6:0]     wordsFull;

  // incoming memory words queue here so the host bus can run ahead of the file
  cpm_fifo #(.WIDTH(W), .DEPTH(cpm_pkg::FIFO_DEPTH)) u_fifo (
    .mclk     (mclk),
    .rst      (rst),
    .inValid  (memValid),
    .inReady  (memReady),
    .inData   (memData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  assign rdVal     = regFile[s_q.regIdx];
  assign cmdReady  = s_q.cmdReady;
  assign halfOrder = s_q.halfOrder;
  assign hostValid = s_q.hostValid;
  assign hostData  = s_q.hostData;
  assign busy      = s_q.busy;
  // count 0 stands for the maximum; a double constant count is doubled later, where left is set
  assign wordsFull = (cmd.count == '0) ? {1'b0, cpm_pkg::FULL_COUNT}
                                       : {2'b00, cmd.count}; // RL4 RL10

  always_comb begin
    s_d      = s_q;
    fifoPop  = 1'b0;
    regWe    = 1'b0;
    regWData = {rdVal[2*W-1:W], rdVal[W-1:0]};
    if (halfOrderWe && s_q.st == cpm_pkg::CPM_IDLE) begin
      s_d.halfOrder = halfOrderIn;
    end
    if (s_q.hostValid && hostReady) begin
      s_d.hostValid = 1'b0;
    end
    case (s_q.st)
      cpm_pkg::CPM_IDLE: begin
        if (cmdValid && s_q.cmdReady) begin
          s_d.op       = cmd.op;
          s_d.isDbl    = (cmd.fmt == cpm_pkg::CPM_FMT_DOUBLE);
          s_d.regIdx   = cmd.reg_idx;
          s_d.second   = 1'b0;
          s_d.cmdReady = 1'b0;
          s_d.busy     = 1'b1;
          // double counts 1 to 16 give values, counts 0 and 17 to 31 give words
          if (cmd.fmt == cpm_pkg::CPM_FMT_DOUBLE && cmd.count != '0 && cmd.op == cpm_pkg::CPM_OP_BLOCK
              && cmd.count <= 5'h10) begin
            s_d.left = 6'({wordsFull[5:0], 1'b0}); // RL9
          end else begin
            s_d.left = wordsFull[5:0]; // RL4
          end
          s_d.st = (cmd.op == cpm_pkg::CPM_OP_BLOCK) ? cpm_pkg::CPM_LOAD : cpm_pkg::CPM_READ;
        end
      end
      cpm_pkg::CPM_READ: begin
        if (!s_q.hostValid) begin
          s_d.hostValid = 1'b1;
          if (s_q.op == cpm_pkg::CPM_OP_TO_HOST2) begin
            // low half first when the half-order bit is set, else high half
            s_d.hostData   = s_q.halfOrder ? rdVal[W-1:0] : rdVal[2*W-1:W]; // RL1 RL2 RL3
            s_d.pendSecond = s_q.halfOrder ? rdVal[2*W-1:W] : rdVal[W-1:0]; // RL1
            s_d.st         = cpm_pkg::CPM_SEND2;
          end else begin
            s_d.hostData = rdVal[W-1:0];
            s_d.st       = cpm_pkg::CPM_IDLE;
            s_d.cmdReady = 1'b1;
            s_d.busy     = 1'b0;
          end
        end
      end
      cpm_pkg::CPM_SEND2: begin
        if (s_q.hostValid && hostReady) begin
          s_d.hostValid = 1'b1;
          s_d.hostData  = s_q.pendSecond;
          s_d.st        = cpm_pkg::CPM_IDLE;
          s_d.cmdReady  = 1'b1;
          s_d.busy      = 1'b0;
        end
      end
      cpm_pkg::CPM_LOAD: begin
        if (s_q.left == '0) begin
          s_d.st       = cpm_pkg::CPM_IDLE;
          s_d.cmdReady = 1'b1;
          s_d.busy     = 1'b0;
        end else if (fifoValid) begin
          fifoPop = 1'b1;
          s_d.left = s_q.left - 6'h01;
          if (!s_q.isDbl) begin
            regWe    = 1'b1;
            regWData = {rdVal[2*W-1:W], fifoData};
            s_d.regIdx = s_q.regIdx + 1'b1; // RL7 RL8
          end else if (!s_q.second) begin
            s_d.holdHalf = fifoData;
            s_d.second   = 1'b1;
          end else begin
            // an odd host count of 17 to 31 leaves a stray half, which the host must avoid
            regWe    = 1'b1; // RL5
            regWData = s_q.halfOrder ? {fifoData, s_q.holdHalf}
                                     : {s_q.holdHalf, fifoData}; // RL2 RL3
            s_d.second = 1'b0;
            s_d.regIdx = s_q.regIdx + 1'b1; // RL7 RL8
          end
        end
      end
      default: begin
        s_d.st = cpm_pkg::CPM_IDLE;
      end
    endcase
  end

  // state register; the half-order bit comes out of reset at zero
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q           <= '0;
      s_q.st        <= cpm_pkg::CPM_IDLE;
      s_q.halfOrder <= cpm_pkg::HALF_ORDER_RESET; // RL3
      s_q.cmdReady  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
    if (regWe) begin
      regFile[s_q.regIdx] <= regWData;
    end
  end

  // helper count of words popped in the current load
  logic [6:0] popCnt_q;
  always_ff @(posedge mclk) begin
    if (rst || s_q.st == cpm_pkg::CPM_IDLE) popCnt_q <= '0;
    else if (fifoPop) popCnt_q <= popCnt_q + 7'h01;
  end

  a_reset_order: assert property (@(posedge mclk) $fell(rst) |-> !halfOrder) // RL3
    else $error("half-order bit not zero after reset");
  a_dbl_first_half: assert property (@(posedge mclk) disable iff (rst) // RL1
    (s_q.st == cpm_pkg::CPM_READ && s_q.op == cpm_pkg::CPM_OP_TO_HOST2 && !s_q.hostValid)
    |=> hostValid && hostData == (halfOrder ? $past(rdVal[W-1:0]) : $past(rdVal[2*W-1:W])))
    else $error("wrong first half to host");
  a_dbl_second: assert property (@(posedge mclk) disable iff (rst) // RL2
    (s_q.st == cpm_pkg::CPM_SEND2 && hostValid && hostReady)
    |=> hostValid && s_q.st == cpm_pkg::CPM_IDLE)
    else $error("second half not sent");
  a_step_single: assert property (@(posedge mclk) disable iff (rst) // RL7
    (fifoPop && !s_q.isDbl) |=> s_q.regIdx == $past(s_q.regIdx) + 1'b1)
    else $error("single destination did not step");
  a_step_double: assert property (@(posedge mclk) disable iff (rst) // RL8
    (fifoPop && s_q.isDbl && !s_q.second) |=> s_q.regIdx == $past(s_q.regIdx))
    else $error("double destination stepped early");
  a_count_zero: assert property (@(posedge mclk) disable iff (rst) // RL4
    (cmdValid && cmdReady && cmd.op == cpm_pkg::CPM_OP_BLOCK && cmd.count == '0)
    |=> s_q.left == 6'h20)
    else $error("count zero not 32 transfers");
  a_dbl_const: assert property (@(posedge mclk) disable iff (rst) // RL9
    (cmdValid && cmdReady && cmd.op == cpm_pkg::CPM_OP_BLOCK && cmd.fmt == cpm_pkg::CPM_FMT_DOUBLE
     && cmd.count != '0 && cmd.count <= 5'h10) |=> s_q.left == {$past(cmd.count), 1'b0})
    else $error("double constant count not doubled");
  a_load_end: assert property (@(posedge mclk) disable iff (rst) // RL10
    (s_q.st == cpm_pkg::CPM_LOAD && s_q.left == '0) |=> s_q.st == cpm_pkg::CPM_IDLE && cmdReady)
    else $error("load did not end after count");
  a_pop_bound: assert property (@(posedge mclk) disable iff (rst) // RL4
    s_q.st == cpm_pkg::CPM_LOAD |-> popCnt_q <= 7'h20)
    else $error("too many words taken");

  // the half-order bit moves only on a write taken in idle
  a_half_held: assert property (@(posedge mclk) disable iff (rst) // RL3
    !(halfOrderWe && s_q.st == cpm_pkg::CPM_IDLE) |=> $stable(halfOrder))
    else $error("half-order bit changed without an idle write");

  // an idle write loads the half-order bit on the next edge
  a_half_write: assert property (@(posedge mclk) disable iff (rst) // RL2
    (halfOrderWe && s_q.st == cpm_pkg::CPM_IDLE) |=> halfOrder == $past(halfOrderIn))
    else $error("half-order write lost");

  // a host word stands unchanged until the host takes it
  a_host_hold: assert property (@(posedge mclk) disable iff (rst) // RL1
    (hostValid && !hostReady) |=> hostValid && $stable(hostData))
    else $error("host word dropped before it was taken");

  // the second host word is the half that the first one left behind
  a_second_half: assert property (@(posedge mclk) disable iff (rst) // RL3
    (s_q.st == cpm_pkg::CPM_SEND2 && hostValid && hostReady)
    |=> hostData == (halfOrder ? $past(rdVal[2*W-1:W]) : $past(rdVal[W-1:0])))
    else $error("wrong second half to host");

  // a nonzero single or integer count gives exactly that many words
  a_word_count: assert property (@(posedge mclk) disable iff (rst) // RL4
    (cmdValid && cmdReady && cmd.op == cpm_pkg::CPM_OP_BLOCK
     && cmd.fmt != cpm_pkg::CPM_FMT_DOUBLE && cmd.count != '0)
    |=> s_q.left == {1'b0, $past(cmd.count)})
    else $error("register count not taken as words");

  // each word taken in a load counts down the words still to go
  a_load_count: assert property (@(posedge mclk) disable iff (rst) // RL4
    (fifoPop && s_q.st == cpm_pkg::CPM_LOAD) |=> s_q.left == $past(s_q.left) - 6'h01)
    else $error("load count did not step");

  // the second word of a double value closes the pair and steps on
  a_pair_step: assert property (@(posedge mclk) disable iff (rst) // RL7
    (fifoPop && s_q.isDbl && s_q.second)
    |=> !s_q.second && s_q.regIdx == $past(s_q.regIdx) + 1'b1)
    else $error("double destination did not step after its pair");
endmodule

// >>> sim/cpm_host_model.sv
// host-side partner: feeds memory words and takes register words
`timescale 1ns/10ps
module cpm_host_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic        pre,
  input  wire logic        slow,
  input  wire logic [31:0] base,
  input  wire logic [6:0]  nWords,
  output logic             memValid,
  input  wire logic        memReady,
  output logic [31:0]      memData,
  input  wire logic        hostValid,
  output logic             hostReady,
  input  wire logic [31:0] hostData,
  output logic [31:0]      got0,
  output logic [31:0]      got1
);
  logic [31:0] addr;
  logic [6:0]  left;
  logic        gap;
  logic        tick;
  // word data equals its bit address; released lines show the inverse
  assign memValid  = (left != 7'h00) && !gap;
  assign memData   = memValid ? addr : ~addr;
  assign hostReady = !(slow && tick);
  // slow mode leaves a gap only after a taken word, so valid never drops early
  always @(posedge mclk) begin
    tick <= #1 rst ? 1'b0 : ~tick;
    gap  <= #1 !rst && slow && memValid && memReady;
    if (rst) begin
      left <= #1 7'h00;
    end else if (load) begin
      addr <= #1 pre ? base - 32'h20 : base;
      left <= #1 nWords;
    end else if (memValid && memReady) begin
      addr <= #1 pre ? addr - 32'h20 : addr + 32'h20;
      left <= #1 left - 7'h01;
    end
    if (hostValid && hostReady) begin
      got0 <= #1 got1;
      got1 <= #1 hostData;
    end
  end
endmodule

// >>> sim/tb_cpm_move_port.sv
// self-checking bench for the coprocessor move port
`timescale 1ns/10ps
module tb_cpm_move_port;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              cmdValid = 1'b0;
  logic              halfOrderWe = 1'b0;
  logic              halfOrderIn = 1'b0;
  logic              load = 1'b0;
  logic              pre = 1'b0;
  logic              slow = 1'b0;
  logic [31:0]       base = 32'h0;
  logic [6:0]        nWords = 7'h00;
  cpm_pkg::cpm_cmd_t cmd = '0;
  logic              cmdReady, halfOrder, memValid, memReady, hostValid, hostReady, busy;
  logic [31:0]       memData, hostData, got0, got1;
  int                nFail = 0;
  int                checked = 0;

  always #25 mclk = ~mclk;

  cpm_move_port dut_u (.mclk(mclk), .rst(rst), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmd(cmd), .halfOrderWe(halfOrderWe), .halfOrderIn(halfOrderIn), .halfOrder(halfOrder),
    .memValid(memValid), .memReady(memReady), .memData(memData), .hostValid(hostValid),
    .hostReady(hostReady), .hostData(hostData), .busy(busy));
  cpm_host_model host_u (.mclk(mclk), .rst(rst), .load(load), .pre(pre), .slow(slow),
    .base(base), .nWords(nWords), .memValid(memValid), .memReady(memReady),
    .memData(memData), .hostValid(hostValid), .hostReady(hostReady), .hostData(hostData),
    .got0(got0), .got1(got1));

  // verdict and end of run, also reached when a wait runs out
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      nFail++;
    end
  endtask

  // offer a command, hold it to the taking edge, then wait for completion
  task automatic issue(cpm_pkg::cpm_op_t op, cpm_pkg::cpm_fmt_t fm, logic [4:0] ix,
                       logic [4:0] cn);
    int i;
    cmd = '{op, fm, ix, cn};
    cmdValid = 1'b1;
    for (i = 0; i < 50 && cmdReady !== 1'b1; i++) @(posedge mclk) #1;
    if (i == 50) begin
      nFail++;
      conclude();
    end
    @(posedge mclk) #1;
    cmdValid = 1'b0;
    for (i = 0; i < 400 && (busy !== 1'b0 || cmdReady !== 1'b1); i++) @(posedge mclk) #1;
    if (i == 400) begin
      nFail++;
      conclude();
    end
  endtask

  task automatic setHalf(logic v);
    halfOrderIn = v;
    halfOrderWe = 1'b1;
    @(posedge mclk) #1;
    halfOrderWe = 1'b0;
  endtask

  // arm the partner with a pointer and an even word count for double loads
  task automatic feed(logic [31:0] b, logic [6:0] n, logic p);
    base = b;
    nWords = n;
    pre = p;
    load = 1'b1;
    @(posedge mclk) #1;
    load = 1'b0;
  endtask

  // let the partner take every host word, then one edge for its delayed copy
  task automatic drain();
    int i;
    for (i = 0; i < 50 && hostValid !== 1'b0; i++) @(posedge mclk) #1;
    if (i == 50) begin
      nFail++;
      conclude();
    end
    @(posedge mclk) #1;
  endtask

  task automatic rd2(logic [4:0] ix, logic [31:0] e0, logic [31:0] e1);
    issue(cpm_pkg::CPM_OP_TO_HOST2, cpm_pkg::CPM_FMT_DOUBLE, ix, 5'h00);
    drain();
    chk("first half", e0, got0);
    chk("second half", e1, got1);
  endtask

  task automatic rd1(logic [4:0] ix, logic [31:0] e);
    issue(cpm_pkg::CPM_OP_TO_HOST1, cpm_pkg::CPM_FMT_SINGLE, ix, 5'h00);
    drain();
    chk("single word", e, got1);
  endtask

  task automatic t_reset();
    chk("half order", 32'h0, {31'h0, halfOrder});
    chk("cmd ready", 32'h1, {31'h0, cmdReady});
    chk("host valid", 32'h0, {31'h0, hostValid});
    chk("busy", 32'h0, {31'h0, busy});
    $display("test reset done");
  endtask

  task automatic t_dbl();
    feed(32'h1000, 7'h04, 1'b0);
    issue(cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_DOUBLE, 5'h03, 5'h02);
    rd2(5'h03, 32'h1000, 32'h1020);
    rd2(5'h04, 32'h1040, 32'h1060);
    setHalf(1'b1);
    chk("half order", 32'h1, {31'h0, halfOrder});
    feed(32'h2000, 7'h02, 1'b1);
    issue(cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_DOUBLE, 5'h07, 5'h01);
    rd2(5'h07, 32'h1FE0, 32'h1FC0);
    setHalf(1'b0);
    rd2(5'h07, 32'h1FC0, 32'h1FE0);
    $display("test double loads done");
  endtask

  // fill the fifo before any command, then let one load drain it
  task automatic t_fill();
    int i;
    feed(32'h4000, 7'h08, 1'b0);
    for (i = 0; i < 20 && memReady !== 1'b0; i++) @(posedge mclk) #1;
    chk("fifo full", 32'h0, {31'h0, memReady});
    issue(cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_SINGLE, 5'h0A, 5'h08);
    chk("fifo drained", 32'h1, {31'h0, memReady});
    rd1(5'h11, 32'h40E0);
    rd1(5'h0A, 32'h4000);
    $display("test fifo fill done");
  endtask

  // count field zero means the maximum, the integer load with a stalling partner
  task automatic t_max();
    slow = 1'b1;
    feed(32'h8000, 7'h20, 1'b0);
    issue(cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_INT, 5'h00, 5'h00);
    rd1(5'h1F, 32'h83E0);
    rd1(5'h00, 32'h8000);
    slow = 1'b0;
    feed(32'hC000, 7'h20, 1'b0);
    issue(cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_DOUBLE, 5'h00, 5'h00);
    rd2(5'h0F, 32'hC3C0, 32'hC3E0);
    $display("test maximum counts done");
  endtask

  // a busy engine turns away commands and half-order writes
  task automatic t_refuse();
    cmd = '{cpm_pkg::CPM_OP_BLOCK, cpm_pkg::CPM_FMT_SINGLE, 5'h14, 5'h01};
    cmdValid = 1'b1;
    @(posedge mclk) #1;
    cmdValid = 1'b0;
    setHalf(1'b1);
    chk("refused half order", 32'h0, {31'h0, halfOrder});
    chk("busy cmd ready", 32'h0, {31'h0, cmdReady});
    chk("busy flag", 32'h1, {31'h0, busy});
    feed(32'h6000, 7'h01, 1'b0);
    rd1(5'h14, 32'h6000);
    $display("test refusal done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_dbl();
    t_fill();
    t_refuse();
    t_max();
    conclude();
  end
endmodule
